// ### sdr_pkg.sv
// constants and types for the 32-bit spi command decode and register read block
package sdr_pkg;
    localparam int FRAME_BITS = 32;
    localparam logic [5:0] FRAME_CNT = 6'h20;
    localparam logic [3:0] CMD_NULL = 4'h0;
    localparam logic [3:0] CMD_REG_WRITE = 4'h8;
    localparam logic [3:0] CMD_REG_READ = 4'hC;
    localparam logic [3:0] RESP_READ_OK = 4'h6;
    localparam logic [3:0] RESP_WRITE_OK = 4'h4;
    localparam logic [1:0] ST_ERROR = 2'h3;
    localparam logic [23:0] RESET_PAYLOAD = 24'h0C0000;
    // request kinds reported on the decode outputs
    localparam logic [2:0] KIND_SENSOR = 3'h0;
    localparam logic [2:0] KIND_WRITE = 3'h1;
    localparam logic [2:0] KIND_READ = 3'h2;
    localparam logic [2:0] KIND_RESERVED = 3'h3;
    localparam logic [2:0] KIND_NULL = 3'h4;
    typedef enum logic [1:0] {
        SDR_IDLE = 2'b00,
        SDR_SHIFT = 2'b01,
        SDR_FINISH = 2'b11
    } sdr_state_e;
endpackage

// ### sdr_spi_slave.sv
// spi slave: frame shifting, command decode, register read and error replies
`timescale 1ns/100ps
module sdr_spi_slave import sdr_pkg::*; (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic SCLK,
    input wire logic SS_N,
    input wire logic MOSI,
    output logic MISO,
    output logic MISO_OE,
    output logic [6:0] REG_WORD_ADDR,
    input wire logic [7:0] REG_HIGH_BYTE,
    input wire logic [7:0] REG_LOW_BYTE,
    input wire logic SPI_ERR,
    input wire logic MISO_ERR,
    input wire logic [1:0] BASIC_STATUS,
    input wire logic [1:0] DETAIL_STATUS,
    input wire logic [11:0] SENSOR_SAMPLE,
    input wire logic SENSOR_VALID,
    output logic [23:0] RESP_PAYLOAD,
    input wire logic [7:0] RESP_CRC,
    output logic REQ_PULSE,
    output logic [2:0] REQ_KIND,
    output logic [2:0] DATA_SOURCE_ID
);
    logic [2:0] sclk_meta_reg;
    logic [2:0] sclk_sync_reg;
    logic sclk_prev_reg;
    logic ss_prev_reg;
    sdr_state_e state_reg;
    logic [5:0] bit_cnt_reg;
    logic [31:0] rx_reg;
    logic [31:0] tx_reg;
    logic [23:0] payload_next;
    logic sclk_rise;
    logic sclk_fall;
    logic ss_fall;
    logic ss_rise;
    logic [3:0] cmd;
    logic spi_bad;
    logic read_bad;

    // two-stage synchronisers; index 0 sclk, 1 select, 2 data
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sclk_meta_reg <= 3'h2;
            sclk_sync_reg <= 3'h2;
            sclk_prev_reg <= 1'b0;
            ss_prev_reg <= 1'b1;
        end
        else
        begin
            sclk_meta_reg <= {MOSI, SS_N, SCLK};
            sclk_sync_reg <= sclk_meta_reg;
            sclk_prev_reg <= sclk_sync_reg[0];
            ss_prev_reg <= sclk_sync_reg[1];
        end
    end

    // edges only count inside a frame, so idle-time toggles are harmless
    assign sclk_rise = sclk_sync_reg[0] & ~sclk_prev_reg & (state_reg == SDR_SHIFT);
    assign sclk_fall = ~sclk_sync_reg[0] & sclk_prev_reg & (state_reg == SDR_SHIFT);
    assign ss_fall = ~sclk_sync_reg[1] & ss_prev_reg;
    assign ss_rise = sclk_sync_reg[1] & ~ss_prev_reg;

    // frame sequencing
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            state_reg <= SDR_IDLE;
        else
        begin
            case (state_reg)
                SDR_IDLE: if (ss_fall) state_reg <= SDR_SHIFT;
                SDR_SHIFT: if (ss_rise) state_reg <= SDR_FINISH;
                SDR_FINISH: state_reg <= SDR_IDLE;
                default: state_reg <= SDR_IDLE;
            endcase
        end
    end

    // receive shifter, msb first on rising sclk; count saturates past a full frame
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rx_reg <= 32'h0;
            bit_cnt_reg <= 6'h0;
        end
        else if (ss_fall && state_reg == SDR_IDLE)
            bit_cnt_reg <= 6'h0;
        else if (sclk_rise)
        begin
            rx_reg <= {rx_reg[30:0], sclk_sync_reg[2]};
            if (bit_cnt_reg <= FRAME_CNT)
                bit_cnt_reg <= bit_cnt_reg + 6'h1;
        end
    end

    // word address leaves as soon as bits 23..16 are in; bit 16 is dropped
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            REG_WORD_ADDR <= 7'h0;
        else if (state_reg == SDR_SHIFT && bit_cnt_reg == 6'h10)
            REG_WORD_ADDR <= rx_reg[7:1];
    end

    // transmit shifter: first bit valid at select fall, next bit on each falling sclk
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tx_reg <= 32'h0;
            MISO <= 1'b0;
            MISO_OE <= 1'b0;
        end
        else if (state_reg == SDR_IDLE && ss_fall)
        begin
            tx_reg <= {RESP_PAYLOAD, RESP_CRC};
            MISO <= RESP_PAYLOAD[23];
            MISO_OE <= 1'b1;
        end
        else if (sclk_fall)
        begin
            tx_reg <= {tx_reg[30:0], 1'b0};
            MISO <= tx_reg[30];
        end
        else if (state_reg != SDR_SHIFT)
        begin
            MISO <= 1'b0;
            MISO_OE <= 1'b0;
        end
    end

    // reply builder; a short or long frame counts as a frame error too
    always_comb
    begin
        cmd = rx_reg[31:28];
        spi_bad = SPI_ERR | (bit_cnt_reg != FRAME_CNT);
        read_bad = spi_bad | MISO_ERR;
        payload_next = {CMD_NULL, ST_ERROR, 2'b00, REG_HIGH_BYTE, REG_LOW_BYTE};
        if (cmd[0])
        begin
            if (!SENSOR_VALID)
                payload_next = {CMD_NULL, ST_ERROR, 12'h000, 4'h0, DETAIL_STATUS};
            // echo puts code bit 0 first, then the source bits, as the reply field expects
            else if (spi_bad)
                payload_next = {cmd[0], cmd[3:1], ST_ERROR, SENSOR_SAMPLE, 4'h0, DETAIL_STATUS};
            else
                payload_next = {cmd[0], cmd[3:1], BASIC_STATUS, SENSOR_SAMPLE, 4'h0, DETAIL_STATUS};
        end
        else if (cmd == CMD_REG_READ && !read_bad)
            payload_next = {RESP_READ_OK, BASIC_STATUS, 2'b00, REG_HIGH_BYTE, REG_LOW_BYTE};
        else if (cmd == CMD_REG_WRITE && !spi_bad)
            payload_next = {RESP_WRITE_OK, BASIC_STATUS, 2'b00, REG_HIGH_BYTE, REG_LOW_BYTE};
    end

    // reply and register pair captured once, as select rises
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            RESP_PAYLOAD <= RESET_PAYLOAD;
        else if (state_reg == SDR_FINISH)
            RESP_PAYLOAD <= payload_next;
    end

    // decode report, one pulse per finished frame
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            REQ_PULSE <= 1'b0;
            REQ_KIND <= KIND_NULL;
            DATA_SOURCE_ID <= 3'h0;
        end
        else
        begin
            REQ_PULSE <= (state_reg == SDR_FINISH);
            if (state_reg == SDR_FINISH)
            begin
                DATA_SOURCE_ID <= cmd[3:1];
                if (cmd[0])
                    REQ_KIND <= KIND_SENSOR;
                else if (cmd == CMD_REG_WRITE)
                    REQ_KIND <= KIND_WRITE;
                else if (cmd == CMD_REG_READ)
                    REQ_KIND <= KIND_READ;
                else if (cmd == CMD_NULL)
                    REQ_KIND <= KIND_NULL;
                else
                    REQ_KIND <= KIND_RESERVED;
            end
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    property p_oe_in_frame;
        state_reg == SDR_SHIFT |-> MISO_OE;
    endproperty
    a_oe_in_frame: assert property (p_oe_in_frame) else $error("miso not driven in frame");

    property p_idle_ignores;
        state_reg == SDR_IDLE && !ss_fall |=> $stable(rx_reg) && !MISO_OE;
    endproperty
    a_idle_ignores: assert property (p_idle_ignores) else $error("activity taken while deselected");

    property p_shift_out;
        sclk_fall |=> MISO == $past(tx_reg[30]);
    endproperty
    a_shift_out: assert property (p_shift_out) else $error("miso not next bit");

    property p_reply_next_frame;
        !$stable(RESP_PAYLOAD) |-> $past(state_reg) == SDR_FINISH;
    endproperty
    a_reply_next_frame: assert property (p_reply_next_frame) else $error("reply changed mid frame");

    property p_read_ok;
        state_reg == SDR_FINISH && cmd == CMD_REG_READ && !read_bad |=>
            RESP_PAYLOAD[23:20] == 4'h6 && RESP_PAYLOAD[19:18] == $past(BASIC_STATUS) && RESP_PAYLOAD[17:16] == 2'h0;
    endproperty
    a_read_ok: assert property (p_read_ok) else $error("bad read reply header");

    property p_read_data;
        state_reg == SDR_FINISH && cmd == CMD_REG_READ |=>
            RESP_PAYLOAD[15:0] == {$past(REG_HIGH_BYTE), $past(REG_LOW_BYTE)};
    endproperty
    a_read_data: assert property (p_read_data) else $error("register pair misplaced");

    property p_read_err;
        state_reg == SDR_FINISH && cmd == CMD_REG_READ && (SPI_ERR || MISO_ERR) |=> RESP_PAYLOAD[23:16] == 8'h0C;
    endproperty
    a_read_err: assert property (p_read_err) else $error("read error reply wrong");

    property p_reserved;
        state_reg == SDR_FINISH && !cmd[0] && cmd != CMD_REG_READ && cmd != CMD_REG_WRITE |=>
            RESP_PAYLOAD[23:16] == 8'h0C && REQ_PULSE;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code not errored");

    property p_source_id;
        state_reg == SDR_FINISH && cmd[0] |=> DATA_SOURCE_ID == $past(rx_reg[31:29]) && REQ_KIND == KIND_SENSOR;
    endproperty
    a_source_id: assert property (p_source_id) else $error("source id wrong");

    property p_null_only_error;
        RESP_PAYLOAD[23:20] == CMD_NULL |-> RESP_PAYLOAD[19:18] == ST_ERROR;
    endproperty
    a_null_only_error: assert property (p_null_only_error) else $error("code 0000 without error");

    property p_sensor_nodata;
        state_reg == SDR_FINISH && cmd[0] && !SENSOR_VALID |=>
            RESP_PAYLOAD[23:20] == 4'h0 && RESP_PAYLOAD[15:2] == 14'h0;
    endproperty
    a_sensor_nodata: assert property (p_sensor_nodata) else $error("sensor no-data reply wrong");

    property p_sensor_echo;
        state_reg == SDR_FINISH && cmd[0] && SENSOR_VALID |=> RESP_PAYLOAD[23:20] == {1'b1, $past(cmd[3:1])};
    endproperty
    a_sensor_echo: assert property (p_sensor_echo) else $error("sensor echo code wrong");

    c_read_ok: cover property (state_reg == SDR_FINISH && cmd == CMD_REG_READ && !read_bad);
    c_sensor: cover property (state_reg == SDR_FINISH && cmd[0] && SENSOR_VALID);
    c_reserved: cover property (state_reg == SDR_FINISH && cmd == 4'hA);
endmodule

// ### sdr_spi_master.sv
// behavioural spi master model that drives mode 0 frames of up to 32 bits
`timescale 1ns/100ps
module sdr_spi_master (
    input wire logic clk,
    input wire logic miso,
    output logic sclk,
    output logic ss_n,
    output logic mosi
);
    // idle levels: clock low, select released
    initial
    begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end
    // half period of the 800 ns link clock, launched just after a core edge
    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // one frame of n bits msb first; rx gathers the reply bits
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        ss_n = 1'b0;
        for (int i = 31; i > 31 - n; i--)
        begin
            mosi = tx[i];
            half();
            sclk = 1'b1;
            rx[i] = miso;
            half();
            sclk = 1'b0;
        end
        half();
        ss_n = 1'b1;
        // noise on clock and data while deselected must be ignored
        repeat (2)
        begin
            half();
            sclk = 1'b1;
            mosi = ~mosi;
            half();
            sclk = 1'b0;
        end
        half();
    endtask
endmodule

// ### sdr_spi_slave_test.sv
// self-checking bench for the spi command decode and register read block
`timescale 1ns/100ps
module sdr_spi_slave_test;
    import sdr_pkg::*;
    logic core_clk, rst_n, sclk, ss_n, mosi, miso, miso_oe, miso_float, spi_err, miso_err, valid, req_pulse;
    logic [1:0] bstat, dstat;
    logic [11:0] sample;
    logic [6:0] word_addr;
    logic [7:0] salt, crc;
    logic [23:0] payload, exp_pay;
    logic [2:0] kind, src;
    int n_mismatch, check_count, cycles, pulses, frames;

    sdr_spi_slave i_sdr_spi_slave (.CORE_CLK(core_clk), .RST_N(rst_n), .SCLK(sclk), .SS_N(ss_n), .MOSI(mosi),
        .MISO(miso), .MISO_OE(miso_oe), .REG_WORD_ADDR(word_addr), .REG_HIGH_BYTE({word_addr, 1'b1} ^ salt),
        .REG_LOW_BYTE({word_addr, 1'b0} ^ salt), .SPI_ERR(spi_err), .MISO_ERR(miso_err), .BASIC_STATUS(bstat),
        .DETAIL_STATUS(dstat), .SENSOR_SAMPLE(sample), .SENSOR_VALID(valid), .RESP_PAYLOAD(payload),
        .RESP_CRC(crc), .REQ_PULSE(req_pulse), .REQ_KIND(kind), .DATA_SOURCE_ID(src));
    sdr_spi_master i_sdr_spi_master (.clk(core_clk), .miso(miso_oe ? miso : miso_float), .sclk(sclk),
        .ss_n(ss_n), .mosi(mosi));

    // stand-in checksum, the real polynomial lives outside this block
    assign crc = payload[23:16] ^ payload[15:8] ^ payload[7:0] ^ 8'h5A;
    // clock
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // released output line toggles so a late enable cannot pass unseen
    always @(posedge core_clk)
    begin
        miso_float <= ~miso_float;
        cycles <= cycles + 1;
        if (req_pulse === 1'b1)
            pulses <= pulses + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // expected reply payload for a request, from the map model
    function automatic logic [23:0] reply(input logic [3:0] c, input logic [6:0] a, input logic err);
        logic [15:0] pair;
        pair = {{a, 1'b1} ^ salt, {a, 1'b0} ^ salt};
        if (c[0])
            return valid ? {c[0], c[3:1], err ? ST_ERROR : bstat, sample, 4'h0, dstat} : {CMD_NULL, ST_ERROR, 16'h0, dstat};
        if (c == CMD_REG_READ && !err && !miso_err)
            return {RESP_READ_OK, bstat, 2'b00, pair};
        if (c == CMD_REG_WRITE && !err)
            return {RESP_WRITE_OK, bstat, 2'b00, pair};
        return {CMD_NULL, ST_ERROR, 2'b00, pair};
    endfunction
    // one frame: judge the reply to the previous request, then this request's effects
    task automatic send(input logic [3:0] c, input logic [7:0] a, input int n);
        logic [31:0] rx;
        logic [31:0] e;
        e = {exp_pay, exp_pay[23:16] ^ exp_pay[15:8] ^ exp_pay[7:0] ^ 8'h5A};
        i_sdr_spi_master.xfer({c, 4'h0, a, 8'h00, 8'hC3}, n, rx);
        frames++;
        check("reply", rx >> (32 - n), e >> (32 - n));
        exp_pay = reply(c, a[7:1], spi_err || n != 32);
        check("payload", payload, exp_pay);
        check("word address", word_addr, a[7:1]);
        check("output enable", miso_oe, 1'b0);
        // a short frame leaves the command misaligned, so decode is judged on whole frames only
        if (n == 32)
        begin
            check("source", src, c[3:1]);
            check("kind", kind, c[0] ? KIND_SENSOR : c == CMD_REG_WRITE ? KIND_WRITE :
                c == CMD_REG_READ ? KIND_READ : KIND_RESERVED);
        end
    endtask
    task automatic t_reset();
        exp_pay = {CMD_NULL, ST_ERROR, 18'h0};
        check("reset payload", payload, exp_pay);
        check("reset kind", kind, KIND_NULL);
        $display("test reset done");
    endtask
    // boundary words, both byte selects, map changing between frames
    task automatic t_read();
        salt = 8'h3C;
        send(CMD_REG_READ, 8'h00, 32);
        send(CMD_REG_READ, 8'hFF, 32);
        salt = 8'hA5;
        send(CMD_REG_READ, 8'h4A, 32);
        send(CMD_REG_READ, 8'h4B, 32);
        $display("test read done");
    endtask
    task automatic t_err();
        spi_err = 1'b1;
        send(CMD_REG_READ, 8'h12, 32);
        spi_err = 1'b0;
        miso_err = 1'b1;
        send(CMD_REG_READ, 8'h34, 32);
        miso_err = 1'b0;
        send(CMD_REG_READ, 8'h56, 31);
        send(CMD_REG_WRITE, 8'h78, 32);
        // frame error on a sensor request with data, then on a write
        spi_err = 1'b1;
        valid = 1'b1;
        sample = 12'h3C9;
        send(4'h5, 8'h00, 32);
        send(CMD_REG_WRITE, 8'h9A, 32);
        spi_err = 1'b0;
        valid = 1'b0;
        $display("test errors done");
    endtask
    // every nonzero code, sensor data valid on codes with bit 1 set
    task automatic t_codes();
        for (int i = 1; i < 16; i++)
        begin
            valid = i[1];
            bstat = i[3:2];
            dstat = ~i[1:0];
            sample = 12'hA50 + 12'(i);
            send(4'(i), i[0] ? 8'h00 : 8'(i * 9), 32);
        end
        $display("test codes done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // main sequence
    initial
    begin
        {rst_n, spi_err, miso_err, valid, miso_float, bstat, dstat, sample, salt} = '0;
        {n_mismatch, check_count, cycles, pulses, frames} = '0;
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        t_reset();
        t_read();
        t_err();
        t_codes();
        send(CMD_REG_READ, 8'h02, 32);
        check("pulses", pulses, frames);
        complete_run();
    end
endmodule
